// file: rtl/oled_port_map.svh
// register-free constants for the parallel host port: command codes,
// field positions and timing figures; assumes a 10 MHz system clock.
`ifndef OLED_PORT_MAP_SVH
`define OLED_PORT_MAP_SVH

`define CMD_DISPLAY_OFF   8'hae
`define CMD_DISPLAY_ON    8'haf
`define CMD_CONTRAST      8'h81
`define CMD_MULTIPLEX     8'ha8
`define CMD_SEG_REMAP     8'ha0
`define CMD_OFFSET        8'hd3
`define CMD_START_LINE    8'h40
`define CMD_SCAN_DIR      8'hc8
`define CMD_COM_PINS      8'hda
`define CMD_PRECHARGE     8'hd9
`define CMD_COMH_LEVEL    8'hdb
`define CMD_ENTIRE_ON     8'ha4
`define CMD_NORMAL        8'ha6
`define CMD_INVERSE       8'ha7

`define RST_CONTRAST      8'h7f
`define RST_MULTIPLEX     8'h3f
`define RST_OFFSET        8'h00
`define RST_COM_PINS      8'h12
`define RST_PRECHARGE     8'h22
`define RST_COMH_LEVEL    8'h20
`define RST_START_LINE    6'h00

`define PRE_HI            7:4
`define PRE_LO            3:0
`define START_FIELD       5:0

`define CLK_PERIOD_NS     100
`define ACC_TIME_NS       140
`endif

// file: rtl/oled_port_pkg.sv
// types shared by the parallel host port.
// assumes nothing beyond a SystemVerilog compiler.
package oled_port_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		PX_IDLE,
		PX_READ,
		PX_WRITE
	} xfer_e;
endpackage

// file: rtl/oled_host_port.sv
// 8080-style parallel host port with command decoder and config store.
// assumes asynchronous host pins; every pin input is synchronised here.
`timescale 1ns/1ps
`include "oled_port_map.svh"

module oled_host_port
#(
	parameter int unsigned DATA_W = 8
) (
	// system
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	// host pins, all asynchronous
	input  wire logic                 chip_select_n,
	input  wire logic                 read_n,
	input  wire logic                 write_n,
	input  wire logic                 data_cmd,
	input  wire logic                 chip_reset_n,
	input  wire logic [DATA_W-1:0]    host_byte_bus_i,
	output logic      [DATA_W-1:0]    host_byte_bus_o,
	output logic                      host_byte_bus_oe,
	// display data stream to the panel memory
	output logic      [DATA_W-1:0]    pixel_data,
	output logic                      pixel_valid,
	// configuration state
	output logic                      display_on,
	output logic      [7:0]           contrast,
	output logic      [7:0]           multiplex,
	output logic      [7:0]           display_offset,
	output logic      [5:0]           start_line,
	output logic      [7:0]           com_pins,
	output logic      [3:0]           precharge_phase,
	output logic      [3:0]           discharge_phase,
	output logic      [7:0]           common_high_level,
	output logic                      seg_remap,
	output logic                      scan_reverse,
	output logic                      entire_on,
	output logic                      invert
);
	import oled_port_pkg::*;

	localparam int unsigned SYNC_W = 4 + DATA_W;

	// returns 1 for commands that expect one parameter byte
	function automatic logic takes_param(input byte_t c);
		return (c == `CMD_CONTRAST) || (c == `CMD_MULTIPLEX) ||
			(c == `CMD_OFFSET) || (c == `CMD_COM_PINS) ||
			(c == `CMD_PRECHARGE) || (c == `CMD_COMH_LEVEL);
	endfunction

	// two-flop synchronisers for every pin; stage one is read by stage two only
	logic [SYNC_W-1:0] s1_q;
	logic [SYNC_W-1:0] s2_q;
	logic [SYNC_W-1:0] pins;
	assign pins = {chip_select_n, read_n, write_n, data_cmd,
		host_byte_bus_i};
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_q <= '1;
			s2_q <= '1;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
		end
	end

	wire               cs_s  = ~s2_q[DATA_W+3];
	wire               rd_ns = s2_q[DATA_W+2];
	wire               wr_ns = s2_q[DATA_W+1];
	wire               dc_s  = s2_q[DATA_W];
	wire  [DATA_W-1:0] bus_s = s2_q[DATA_W-1:0];

	// reset pin synchroniser, kept apart so it does not gate the byte path
	logic rn1_q;
	logic rn2_q;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rn1_q <= 1'b0;
			rn2_q <= 1'b0;
		end else begin
			rn1_q <= chip_reset_n;
			rn2_q <= rn1_q;
		end
	end
	wire init_hold = rst | ~rn2_q;

	// transfer tracking: a write is captured when the strobe or select
	// rises, since data only settles after the falling edge
	xfer_e       st_q;
	xfer_e       st_d;
	logic        dc_q;
	logic        dc_d;
	logic [DATA_W-1:0] byte_q;
	logic [DATA_W-1:0] byte_d;
	wire rd_start = cs_s & ~rd_ns;
	wire wr_start = cs_s & ~wr_ns;
	wire wr_end   = (st_q == PX_WRITE) & (wr_ns | ~cs_s);
	wire rd_end   = (st_q == PX_READ) & (rd_ns | ~cs_s);

	always_comb begin
		st_d   = st_q;
		dc_d   = dc_q;
		byte_d = byte_q;
		unique case (st_q)
			PX_IDLE: begin
				if (wr_start)
					st_d = PX_WRITE;
				else if (rd_start)
					st_d = PX_READ;
			end
			PX_WRITE: begin
				if (wr_end)
					st_d = PX_IDLE;
				else begin
					byte_d = bus_s;
					dc_d   = dc_s;
				end
			end
			PX_READ: begin
				if (rd_end)
					st_d = PX_IDLE;
			end
			default: st_d = PX_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q   <= PX_IDLE;
			dc_q   <= 1'b0;
			byte_q <= '0;
		end else begin
			st_q   <= init_hold ? PX_IDLE : st_d;
			dc_q   <= dc_d;
			byte_q <= byte_d;
		end
	end

	// completed write, split by the captured data/command level
	wire wr_done  = wr_end & ~init_hold;
	wire is_data  = wr_done & dc_q;
	wire is_cmd   = wr_done & ~dc_q;
	wire [7:0] cb = byte_q[7:0];

	// pending parameter: holds the opcode awaiting its argument
	logic       pend_q;
	logic [7:0] op_q;
	wire        is_param = is_cmd & pend_q;
	wire        is_op    = is_cmd & ~pend_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
			op_q   <= 8'h00;
		end else if (init_hold) begin
			pend_q <= 1'b0;
		end else if (is_op) begin
			pend_q <= takes_param(cb);
			op_q   <= cb;
		end else if (is_param) begin
			pend_q <= 1'b0;
		end
	end

	// display data stream, registered one-cycle strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pixel_data  <= '0;
			pixel_valid <= 1'b0;
		end else begin
			pixel_valid <= is_data;
			if (is_data)
				pixel_data <= byte_q;
		end
	end

	// single-byte commands; the recommended bring-up opens with display
	// off and closes with normal, non-inverted, on
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			display_on   <= 1'b0;
			seg_remap    <= 1'b0;
			scan_reverse <= 1'b0;
			entire_on    <= 1'b0;
			invert       <= 1'b0;
			start_line   <= `RST_START_LINE;
		end else if (init_hold) begin
			display_on   <= 1'b0;
			seg_remap    <= 1'b0;
			scan_reverse <= 1'b0;
			entire_on    <= 1'b0;
			invert       <= 1'b0;
			start_line   <= `RST_START_LINE;
		end else if (is_op) begin
			if (cb == `CMD_DISPLAY_OFF)
				display_on <= 1'b0;
			if (cb == `CMD_DISPLAY_ON)
				display_on <= 1'b1;
			if (cb[7:1] == 7'(`CMD_SEG_REMAP >> 1))
				seg_remap <= cb[0];
			if (cb == `CMD_SCAN_DIR)
				scan_reverse <= 1'b1;
			if (cb[7:1] == 7'(`CMD_ENTIRE_ON >> 1))
				entire_on <= cb[0];
			if (cb == `CMD_NORMAL)
				invert <= 1'b0;
			if (cb == `CMD_INVERSE)
				invert <= 1'b1;
			if (cb[7:6] == 2'(`CMD_START_LINE >> 6))
				start_line <= cb[`START_FIELD];
		end
	end

	// parameter bytes complete the two-byte commands
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			contrast          <= `RST_CONTRAST;
			multiplex         <= `RST_MULTIPLEX;
			display_offset    <= `RST_OFFSET;
			com_pins          <= `RST_COM_PINS;
			precharge_phase   <= 4'(`RST_PRECHARGE >> 4);
			discharge_phase   <= 4'(`RST_PRECHARGE);
			common_high_level <= `RST_COMH_LEVEL;
		end else if (init_hold) begin
			contrast          <= `RST_CONTRAST;
			multiplex         <= `RST_MULTIPLEX;
			display_offset    <= `RST_OFFSET;
			com_pins          <= `RST_COM_PINS;
			precharge_phase   <= 4'(`RST_PRECHARGE >> 4);
			discharge_phase   <= 4'(`RST_PRECHARGE);
			common_high_level <= `RST_COMH_LEVEL;
		end else if (is_param) begin
			unique case (op_q)
				`CMD_CONTRAST:   contrast <= cb;
				`CMD_MULTIPLEX:  multiplex <= cb;
				`CMD_OFFSET:     display_offset <= cb;
				`CMD_COM_PINS:   com_pins <= cb;
				`CMD_PRECHARGE: begin
					precharge_phase <= cb[`PRE_HI];
					discharge_phase <= cb[`PRE_LO];
				end
				`CMD_COMH_LEVEL: common_high_level <= cb;
				default: ;
			endcase
		end
	end

	// read returns the state byte: display on and pending parameter;
	// bus driven only inside an enabled read, released at its end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			host_byte_bus_o  <= '0;
			host_byte_bus_oe <= 1'b0;
		end else begin
			host_byte_bus_oe <= (st_d == PX_READ) & ~init_hold;
			host_byte_bus_o  <= DATA_W'({display_on, pend_q, 6'h00});
		end
	end

	// read enable only ever follows a selected read strobe
	bus_drive_a: assert property (@(posedge sys_clk) disable iff (rst)
		host_byte_bus_oe |-> $past(cs_s) && !$past(rd_ns))
		else $error("bus driven outside a read");

	// no transfer begins while chip select is high
	sel_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		(st_q == PX_IDLE && !cs_s) |=> st_q == PX_IDLE)
		else $error("transfer started without select");

	// a selected falling write strobe enters the write state
	wr_begin_a: assert property (@(posedge sys_clk) disable iff (rst)
		(st_q == PX_IDLE && wr_start && !init_hold) |=> st_q == PX_WRITE)
		else $error("write strobe not taken");

	rd_begin_a: assert property (@(posedge sys_clk) disable iff (rst)
		(st_q == PX_IDLE && rd_start && wr_ns && !init_hold)
		|=> st_q == PX_READ)
		else $error("read strobe not taken");

	// data writes stream out one cycle after completion
	data_path_a: assert property (@(posedge sys_clk) disable iff (rst)
		is_data |=> pixel_valid && pixel_data == $past(byte_q))
		else $error("display byte lost");

	cmd_nodata_a: assert property (@(posedge sys_clk) disable iff (rst)
		is_cmd |=> !pixel_valid)
		else $error("command leaked as data");

	// a contrast opcode leaves the port waiting for its parameter; data
	// bytes in between must not clear the wait
	sequence contrast_op_s;
		is_op && cb == `CMD_CONTRAST;
	endsequence
	sequence param_wait_s;
		pend_q && op_q == `CMD_CONTRAST;
	endsequence
	contrast_pend_a: assert property (@(posedge sys_clk)
		disable iff (init_hold)
		contrast_op_s |=> param_wait_s)
		else $error("contrast parameter not awaited");

	// a display byte strobes for exactly one cycle
	pix_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
		pixel_valid |=> !pixel_valid)
		else $error("display strobe stretched");

	// init hold releases the bus on the next edge
	bus_init_a: assert property (@(posedge sys_clk) disable iff (rst)
		!rn2_q |=> !host_byte_bus_oe)
		else $error("bus driven during init");

	contrast_set_a: assert property (@(posedge sys_clk)
		disable iff (init_hold)
		is_param && op_q == `CMD_CONTRAST |=> contrast == $past(cb))
		else $error("contrast not stored");

	precharge_a: assert property (@(posedge sys_clk)
		disable iff (init_hold)
		is_param && op_q == `CMD_PRECHARGE |=>
		{precharge_phase, discharge_phase} == $past(cb))
		else $error("precharge nibbles misplaced");

	disp_on_a: assert property (@(posedge sys_clk) disable iff (rst)
		is_op && cb == `CMD_DISPLAY_ON |=> display_on)
		else $error("display on ignored");

	init_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		!rn2_q |=> !display_on && !pend_q && st_q == PX_IDLE)
		else $error("init hold not applied");

endmodule // oled_host_port

// file: dv/host_mcu_model.sv
// host microcontroller model driving the 8080-style parallel port
// assumes sys_clk from the bench; control pins change at falling edges, the released bus toggles at rising edges
`timescale 1ns/1ps
module host_mcu_model (
	// clock
	input  wire logic       sys_clk,
	// host pins
	output logic            cs_n,
	output logic            rd_n,
	output logic            wr_n,
	output logic            dc,
	output logic            chip_reset_n,
	// shared byte bus
	input  wire logic [7:0] dev_byte,
	input  wire logic       dev_oe,
	output logic      [7:0] bus
);
	logic       drv;
	logic [7:0] hb;
	logic [7:0] last_q;
	// a released bus toggles, so a stale byte never passes for a read
	assign bus = dev_oe ? dev_byte : drv ? hb : ~last_q;
	always @(posedge sys_clk) last_q <= bus;
	// idle pin levels from time zero
	initial begin
		{cs_n, rd_n, wr_n, dc, chip_reset_n, drv} = 6'b111110;
		hb = 8'h00;
		last_q = 8'h00;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// reset pin low with select low, released before any command
	task automatic power_up(input int n);
		chip_reset_n = 1'b0;
		cs_n = 1'b0;
		gap(n);
		chip_reset_n = 1'b1;
		cs_n = 1'b1;
		gap(4);
	endtask
	// strobe held 6 cycles, above the 2 the port needs to see it
	task automatic put(input logic d, input logic [7:0] b, input logic s);
		dc = d;
		cs_n = s;
		rd_n = 1'b1;
		wr_n = 1'b0;
		hb = b;
		drv = 1'b1;
		gap(6);
		if (d) begin
			cs_n = 1'b1;
			gap(1);
			wr_n = 1'b1;
		end else begin
			wr_n = 1'b1;
			gap(1);
			cs_n = 1'b1;
		end
		gap(1);
		drv = 1'b0;
		dc = 1'b1;
		gap(6);
	endtask
	// read strobe held low until the answer has settled
	task automatic get(output logic [7:0] b, output logic seen);
		cs_n = 1'b0;
		rd_n = 1'b0;
		gap(6);
		b = bus;
		seen = dev_oe;
		rd_n = 1'b1;
		cs_n = 1'b1;
		gap(6);
	endtask
endmodule // host_mcu_model

// file: dv/testbench.sv
// self-checking bench for the parallel host port with a host model
// assumes the rtl package is compiled first
`timescale 1ns/1ps
module testbench;
	import oled_port_pkg::*;
	logic       sys_clk, rst, oe, pv, don, seg, scn, ent, inv, seen;
	wire logic  cs_n, rd_n, wr_n, dc, chip_reset_n;
	wire logic  [7:0] bus;
	logic [7:0] bo, pix, con, mux, ofs, com, chl, pix_last, rb;
	logic [5:0] stl;
	logic [3:0] pre, dis;
	logic [7:0] exp_cfg [13];
	logic [7:0] ops [15] = '{8'hae, 8'h81, 8'ha8, 8'ha0, 8'hd3, 8'h40,
		8'hc8, 8'hda, 8'hd9, 8'hdb, 8'ha4, 8'ha6, 8'haf, 8'ha1, 8'ha7};
	logic [7:0] prm [13] = '{8'h0, 8'hff, 8'h3f, 8'h0, 8'h00, 8'h0, 8'h0,
		8'h12, 8'hf1, 8'h49, 8'h0, 8'h0, 8'h0};
	int         mismatches, check_count, pix_n, seed, r;
	oled_host_port oled_host_port_inst (.sys_clk(sys_clk), .rst(rst),
		.chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n),
		.data_cmd(dc), .chip_reset_n(chip_reset_n),
		.host_byte_bus_i(bus),
		.host_byte_bus_o(bo), .host_byte_bus_oe(oe), .pixel_data(pix),
		.pixel_valid(pv), .display_on(don), .contrast(con),
		.multiplex(mux), .display_offset(ofs), .start_line(stl),
		.com_pins(com), .precharge_phase(pre), .discharge_phase(dis),
		.common_high_level(chl), .seg_remap(seg), .scan_reverse(scn),
		.entire_on(ent), .invert(inv));
	host_mcu_model host_mcu_model_inst (.sys_clk(sys_clk), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .dc(dc),
		.chip_reset_n(chip_reset_n), .dev_byte(bo),
		.dev_oe(oe), .bus(bus));
	// 10 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// count display bytes as the port hands them on
	always @(posedge sys_clk) begin
		if (pv === 1'b1) begin
			pix_n <= pix_n + 1;
			pix_last <= pix;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("checks=%0d mismatches=%0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// every config output against the expected table
	task automatic chk_cfg;
		logic [7:0] g [13];
		g = '{{7'h0, don}, con, mux, ofs, {2'h0, stl}, com, {4'h0, pre},
			{4'h0, dis}, chl, {7'h0, seg}, {7'h0, scn}, {7'h0, ent},
			{7'h0, inv}};
		for (int i = 0; i < 13; i++) begin
			chk(g[i], exp_cfg[i]);
		end
	endtask
	task automatic cfg_reset;
		exp_cfg = '{8'h0, 8'h7f, 8'h3f, 8'h0, 8'h0, 8'h12, 8'h2, 8'h2,
			8'h20, 8'h0, 8'h0, 8'h0, 8'h0};
	endtask
	// expected effect of one command and its parameter
	task automatic apply(input logic [7:0] op, input logic [7:0] v);
		case (op)
			8'h81: exp_cfg[1] = v;
			8'ha8: exp_cfg[2] = v;
			8'hd3: exp_cfg[3] = v;
			8'hda: exp_cfg[5] = v;
			8'hd9: begin
				exp_cfg[6] = {4'h0, v[7:4]};
				exp_cfg[7] = {4'h0, v[3:0]};
			end
			8'hdb: exp_cfg[8] = v;
			8'hae, 8'haf: exp_cfg[0] = {7'h0, op[0]};
			8'ha0, 8'ha1: exp_cfg[9] = {7'h0, op[0]};
			8'ha6, 8'ha7: exp_cfg[12] = {7'h0, op[0]};
			8'ha4: exp_cfg[11] = 8'h0;
			8'h40: exp_cfg[4] = 8'h0;
			8'hc8: exp_cfg[10] = 8'h1;
			default: ;
		endcase
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] v);
		host_mcu_model_inst.put(1'b0, op, 1'b0);
		if (op inside {8'h81, 8'ha8, 8'hd3, 8'hda, 8'hd9, 8'hdb})
			host_mcu_model_inst.put(1'b0, v, 1'b0);
		apply(op, v);
	endtask
	task automatic rd_chk(input logic [7:0] e);
		host_mcu_model_inst.get(rb, seen);
		chk({7'h0, seen}, 8'h1);
		chk(rb, e);
		chk({7'h0, oe}, 8'h0);
	endtask
	task automatic dat(input logic [7:0] v, input logic s);
		int n;
		n = pix_n;
		host_mcu_model_inst.put(1'b1, v, s);
		chk(8'(pix_n - n), {7'h0, ~s});
		if (!s)
			chk(pix_last, v);
	endtask
	// main sequence
	initial begin
		seed = 32'h0c73;
		mismatches = 0;
		check_count = 0;
		pix_n = 0;
		rst = 1'b1;
		repeat (5) @(negedge sys_clk);
		rst = 1'b0;
		cfg_reset;
		host_mcu_model_inst.power_up(10);
		chk_cfg;
		chk({7'h0, oe}, 8'h0);
		$display("test reset done");
		for (int i = 0; i < 13; i++) begin
			if (i == 12)
				chk({7'h0, don}, 8'h0);
			cmd(ops[i], prm[i]);
		end
		chk_cfg;
		$display("test init done");
		// a data byte must not cancel a pending parameter
		host_mcu_model_inst.put(1'b0, 8'h81, 1'b0);
		rd_chk(8'hc0);
		dat(8'h5a, 1'b0);
		host_mcu_model_inst.put(1'b0, 8'h3c, 1'b0);
		apply(8'h81, 8'h3c);
		rd_chk(8'h80);
		chk_cfg;
		$display("test param done");
		repeat (30) begin
			r = $random(seed);
			if (r[8])
				dat(r[7:0], r[9]);
			else
				host_mcu_model_inst.put(1'b0, r[7:0], 1'b1);
		end
		chk_cfg;
		rd_chk(8'h80);
		$display("test data done");
		repeat (40) begin
			r = $random(seed);
			cmd(ops[r[11:8] % 15], r[7:0]);
			chk_cfg;
		end
		rd_chk({exp_cfg[0][0], 7'h0});
		$display("test random done");
		host_mcu_model_inst.power_up(10);
		cfg_reset;
		chk_cfg;
		rd_chk(8'h00);
		$display("test chip reset done");
		test_done;
	end
	// watchdog, about six times the expected run
	initial begin
		#1000000;
		mismatches++;
		test_done;
	end
endmodule // testbench
